// ==== src/udr_pkg.sv ====
// Constants shared by the serial channel register bank
package udr_pkg;
    // Register addresses on the 3-bit host bus
    localparam logic [2:0] UDR_A_DATA = 3'h0;
    localparam logic [2:0] UDR_A_IER = 3'h1;
    localparam logic [2:0] UDR_A_ISR = 3'h2;
    localparam logic [2:0] UDR_A_LCR = 3'h3;
    localparam logic [2:0] UDR_A_MCR = 3'h4;
    localparam logic [2:0] UDR_A_LSR = 3'h5;
    localparam logic [2:0] UDR_A_MSR = 3'h6;
    localparam logic [2:0] UDR_A_SPR = 3'h7;
    localparam logic [2:0] UDR_A_RESUME_CHAR_ONE = 3'h4;
    localparam logic [2:0] UDR_A_RESUME_CHAR_TWO = 3'h5;
    localparam logic [2:0] UDR_A_PAUSE_CHAR_ONE = 3'h6;
    localparam logic [2:0] UDR_A_PAUSE_CHAR_TWO = 3'h7;
    // Key value in line_control that opens the enhanced bank
    localparam logic [7:0] UDR_ENH_KEY = 8'hBF;
    // Bit positions
    localparam int UDR_LCR_DIV_BIT = 7;
    localparam int UDR_EFR_ENH_BIT = 4;
    localparam int UDR_FCR_EN_BIT = 0;
    localparam int UDR_FCR_RXRST_BIT = 1;
    localparam int UDR_FEATURE_CONTROL_SWAP_BIT = 6;
    localparam int UDR_IER_RX_BIT = 0;
    localparam int UDR_IER_TX_BIT = 1;
    localparam int UDR_IER_LS_BIT = 2;
    localparam int UDR_IER_MS_BIT = 3;
    // Enhanced-only bit masks
    localparam logic [7:0] UDR_IER_ENH_MASK = 8'hF0;
    localparam logic [7:0] UDR_FCR_ENH_MASK = 8'h30;
    localparam logic [7:0] UDR_MCR_ENH_MASK = 8'hE0;
    localparam logic [7:0] UDR_DLD_MASK = 8'h0F;
    // Interrupt status codes, bits 5:0
    localparam logic [5:0] UDR_ISR_LSR = 6'h06;
    localparam logic [5:0] UDR_ISR_TMO = 6'h0C;
    localparam logic [5:0] UDR_ISR_RECEIVE_READY_EVENT = 6'h04;
    localparam logic [5:0] UDR_ISR_TX = 6'h02;
    localparam logic [5:0] UDR_ISR_MSR = 6'h00;
    localparam logic [5:0] UDR_ISR_NONE = 6'h01;
    // Reset value of every writable register
    localparam logic [7:0] UDR_REG_RST = 8'h00;
    // Default FIFO depth in characters
    localparam int UDR_FIFO_DEPTH = 64;
endpackage

// ==== src/udr_irq.sv ====
// Interrupt priority encoder for the serial channel
`timescale 1ns/1ps
`default_nettype none
module udr_irq
    import udr_pkg::*;
(
    // Interrupt sources, all but the timeout gated by their enables
    input wire logic i_src_lsr,
    input wire logic i_src_tmo,
    input wire logic i_src_rx,
    input wire logic i_src_tx,
    input wire logic i_src_msr,
    // Encoded result
    output logic [5:0] o_code,
    output logic o_pending
);
    ////////////////////////////////////////////////////////////////////////
    // Highest pending level wins; lower ones wait their turn
    always_comb begin
        o_pending = 1'b1;
        if (i_src_lsr) begin
            o_code = UDR_ISR_LSR;
        end else if (i_src_tmo) begin
            o_code = UDR_ISR_TMO;
        end else if (i_src_rx) begin
            o_code = UDR_ISR_RECEIVE_READY_EVENT;
        end else if (i_src_tx) begin
            o_code = UDR_ISR_TX;
        end else if (i_src_msr) begin
            o_code = UDR_ISR_MSR;
        end else begin
            // Nothing pending reads as the idle code
            o_code = UDR_ISR_NONE;
            o_pending = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== src/udr_regs.sv ====
// Register bank, receive FIFO and interrupt status of one serial channel
`timescale 1ns/1ps
`default_nettype none
module udr_regs
    import udr_pkg::*;
#(
    parameter int FIFO_DEPTH = UDR_FIFO_DEPTH,
    parameter logic [7:0] REV_CODE = 8'h01, // Arbitrary value
    parameter logic [7:0] PART_ID = 8'h5C // Arbitrary value
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Host bus, one-cycle strobes on i_clk
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Receiver side
    input wire logic i_rx_push,
    input wire logic [7:0] i_rx_char,
    input wire logic [3:0] i_line_err,
    input wire logic i_rx_timeout,
    // Transmitter side
    input wire logic i_thr_empty,
    input wire logic i_tsr_empty,
    output logic o_tx_write,
    output logic [7:0] o_tx_data,
    // Modem status and interrupt
    input wire logic [7:0] i_modem_status,
    output logic o_irq
);
    localparam int PW = $clog2(FIFO_DEPTH);
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    // Pointers wrap naturally only for a power of two; count fits a byte
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 128 ||
        (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_depth_chk
        $error("udr_regs: FIFO_DEPTH must be a power of two, 2 to 128");
    end

    ////////////////////////////////////////////////////////////////////////
    // All state of the bank except the receive character store
    typedef struct packed {
        logic [7:0] line_control; // line_control
        logic [7:0] interrupt_enable; // interrupt_enable
        logic [7:0] fifo_control; // fifo_control (write-only copy)
        logic [7:0] dll; // baud_divisor_low
        logic [7:0] baud_divisor_high; // baud_divisor_high
        logic [7:0] baud_divisor_fraction; // baud_divisor_fraction
        logic [7:0] mcr; // modem control
        logic [7:0] spr; // scratch
        logic [7:0] fifo_trigger_level; // fifo_trigger_level
        logic [7:0] feature_control; // feature_control
        logic [7:0] enhanced_function; // enhanced_function
        logic [7:0] resume_char_one; // resume_char_one
        logic [7:0] resume_char_two; // resume_char_two
        logic [7:0] pause_char_one; // pause_char_one
        logic [7:0] pause_char_two; // pause_char_two
        logic [7:0] rdata; // Read data holding
        logic [PW-1:0] wptr; // FIFO write pointer
        logic [PW-1:0] rptr; // FIFO read pointer
        logic [CW-1:0] cnt; // FIFO fill level
        logic tx_pend; // Transmit-ready latch
        logic thr_empty_d; // Edge detect of holding empty
        logic tx_wr; // Transmit write pulse
        logic [7:0] tx_data; // Transmit character
    } udr_state_t;

    udr_state_t state_reg;
    udr_state_t state_next;
    logic [7:0] fifo_mem [FIFO_DEPTH]; // Receive character store

    // Keep enhanced bits at zero unless the enhanced enable is set
    function automatic logic [7:0] enh_mask(input logic [7:0] v, input logic [7:0] m,
                                            input logic en);
        enh_mask = en ? v : (v & ~m);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Decoded conditions
    logic enh_bank; // Enhanced bank selected by key
    logic div_sel; // Divisor latch bit set
    logic enh_en; // Enhanced bits allowed
    logic div_zero; // Divisor bytes both zero
    logic fifo_mode; // FIFOs enabled
    logic [7:0] cnt8; // Fill level as a byte
    logic rx_ready; // Receive data present
    logic rx_trig; // Trigger condition reached
    logic src_rx; // Gated receive source
    logic src_tx; // Gated transmit source
    logic src_lsr; // Gated line status source
    logic src_msr; // Gated modem status source
    logic [5:0] isr_code; // Encoded status
    logic irq_pend; // Any source pending
    logic [7:0] lsr_val; // Line status view
    logic push; // Accepted receive push
    logic pop; // Host reads a character

    assign enh_bank = (state_reg.line_control == UDR_ENH_KEY);
    assign div_sel = state_reg.line_control[UDR_LCR_DIV_BIT];
    assign enh_en = state_reg.enhanced_function[UDR_EFR_ENH_BIT];
    assign div_zero = (state_reg.dll == 8'h00) && (state_reg.baud_divisor_high == 8'h00);
    assign fifo_mode = state_reg.fifo_control[UDR_FCR_EN_BIT];
    assign cnt8 = 8'(state_reg.cnt);
    assign rx_ready = (state_reg.cnt != '0);
    // Trigger mode needs only the FIFO enable; without it any data counts
    assign rx_trig = fifo_mode ? (rx_ready && cnt8 >= state_reg.fifo_trigger_level) : rx_ready;
    // Level compare: rises at trigger and falls below it with no latch
    assign src_rx = state_reg.interrupt_enable[UDR_IER_RX_BIT] && rx_trig;
    assign src_tx = state_reg.interrupt_enable[UDR_IER_TX_BIT] && state_reg.tx_pend;
    assign src_lsr = state_reg.interrupt_enable[UDR_IER_LS_BIT] && (|i_line_err);
    assign src_msr = state_reg.interrupt_enable[UDR_IER_MS_BIT] && (|i_modem_status[3:0]);
    assign lsr_val = {1'b0, i_tsr_empty, i_thr_empty, i_line_err, rx_ready};
    assign push = i_rx_push && (state_reg.cnt != CW'(FIFO_DEPTH));

    udr_irq u_irq (
        .i_src_lsr(src_lsr),
        .i_src_tmo(i_rx_timeout),
        .i_src_rx(src_rx),
        .i_src_tx(src_tx),
        .i_src_msr(src_msr),
        .o_code(isr_code),
        .o_pending(irq_pend)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register decode, FIFO bookkeeping, transmit-ready latch
    always_comb begin
        state_next = state_reg;
        state_next.tx_wr = 1'b0;
        state_next.thr_empty_d = i_thr_empty;
        pop = 1'b0;
        // Transmit-ready clears are applied first so a new set wins
        if (i_rd && !enh_bank && !div_sel && i_addr == UDR_A_ISR && isr_code == UDR_ISR_TX) begin
            state_next.tx_pend = 1'b0;
        end
        if (i_wr && !enh_bank && !div_sel && i_addr == UDR_A_DATA) begin
            state_next.tx_pend = 1'b0;
            state_next.tx_wr = 1'b1;
            state_next.tx_data = i_wdata;
        end
        if (i_thr_empty && !state_reg.thr_empty_d) begin
            state_next.tx_pend = 1'b1;
        end
        // Reads: enhanced bank first, then divisor view, then normal
        if (i_rd) begin
            state_next.rdata = 8'h00;
            if (enh_bank) begin
                case (i_addr)
                    UDR_A_DATA: state_next.rdata = cnt8;
                    UDR_A_IER: state_next.rdata = state_reg.feature_control;
                    UDR_A_ISR: state_next.rdata = state_reg.enhanced_function;
                    UDR_A_LCR: state_next.rdata = state_reg.line_control;
                    UDR_A_RESUME_CHAR_ONE: state_next.rdata = state_reg.resume_char_one;
                    UDR_A_RESUME_CHAR_TWO: state_next.rdata = state_reg.resume_char_two;
                    UDR_A_PAUSE_CHAR_ONE: state_next.rdata = state_reg.pause_char_one;
                    UDR_A_PAUSE_CHAR_TWO: state_next.rdata = state_reg.pause_char_two;
                    default: state_next.rdata = 8'h00;
                endcase
            end else if (div_sel && i_addr == UDR_A_DATA) begin
                // Zero divisor exposes the revision instead
                state_next.rdata = div_zero ? REV_CODE : state_reg.dll;
            end else if (div_sel && i_addr == UDR_A_IER) begin
                state_next.rdata = div_zero ? PART_ID : state_reg.baud_divisor_high;
            end else if (div_sel && i_addr == UDR_A_ISR) begin
                state_next.rdata = enh_mask(state_reg.baud_divisor_fraction, 8'hFF, enh_en);
            end else begin
                case (i_addr)
                    UDR_A_DATA: begin
                        state_next.rdata = fifo_mem[state_reg.rptr];
                        pop = rx_ready;
                    end
                    UDR_A_IER: state_next.rdata = enh_mask(state_reg.interrupt_enable, UDR_IER_ENH_MASK,
                                                           enh_en);
                    // Code and output come from one encoder, so they clear together
                    UDR_A_ISR: state_next.rdata = {fifo_mode, fifo_mode, isr_code};
                    UDR_A_LCR: state_next.rdata = state_reg.line_control;
                    UDR_A_MCR: state_next.rdata = enh_mask(state_reg.mcr, UDR_MCR_ENH_MASK,
                                                           enh_en);
                    UDR_A_LSR: state_next.rdata = lsr_val;
                    UDR_A_MSR: state_next.rdata = i_modem_status;
                    UDR_A_SPR: state_next.rdata = state_reg.feature_control[UDR_FEATURE_CONTROL_SWAP_BIT] ?
                                                  cnt8 : state_reg.spr;
                    default: state_next.rdata = 8'h00;
                endcase
            end
        end
        // Writes
        if (i_wr) begin
            if (enh_bank) begin
                case (i_addr)
                    UDR_A_DATA: state_next.fifo_trigger_level = i_wdata;
                    UDR_A_IER: state_next.feature_control = i_wdata;
                    UDR_A_ISR: state_next.enhanced_function = i_wdata;
                    UDR_A_LCR: state_next.line_control = i_wdata;
                    UDR_A_RESUME_CHAR_ONE: state_next.resume_char_one = i_wdata;
                    UDR_A_RESUME_CHAR_TWO: state_next.resume_char_two = i_wdata;
                    UDR_A_PAUSE_CHAR_ONE: state_next.pause_char_one = i_wdata;
                    UDR_A_PAUSE_CHAR_TWO: state_next.pause_char_two = i_wdata;
                    default: state_next.line_control = state_reg.line_control;
                endcase
            end else if (div_sel && i_addr == UDR_A_DATA) begin
                state_next.dll = i_wdata;
            end else if (div_sel && i_addr == UDR_A_IER) begin
                state_next.baud_divisor_high = i_wdata;
            end else if (div_sel && i_addr == UDR_A_ISR) begin
                // Fraction is enhanced-only and four bits wide
                if (enh_en) begin
                    state_next.baud_divisor_fraction = i_wdata & UDR_DLD_MASK;
                end
            end else begin
                case (i_addr)
                    UDR_A_IER: begin
                        state_next.interrupt_enable = (i_wdata & ~UDR_IER_ENH_MASK) |
                                         (enh_en ? (i_wdata & UDR_IER_ENH_MASK) :
                                          (state_reg.interrupt_enable & UDR_IER_ENH_MASK));
                        // Enabling while already empty raises transmit ready
                        if (i_wdata[UDR_IER_TX_BIT] && !state_reg.interrupt_enable[UDR_IER_TX_BIT] &&
                            i_thr_empty) begin
                            state_next.tx_pend = 1'b1;
                        end
                    end
                    UDR_A_ISR: state_next.fifo_control = (i_wdata & ~UDR_FCR_ENH_MASK) |
                                               (enh_en ? (i_wdata & UDR_FCR_ENH_MASK) :
                                                (state_reg.fifo_control & UDR_FCR_ENH_MASK));
                    UDR_A_LCR: state_next.line_control = i_wdata;
                    UDR_A_MCR: state_next.mcr = (i_wdata & ~UDR_MCR_ENH_MASK) |
                                               (enh_en ? (i_wdata & UDR_MCR_ENH_MASK) :
                                                (state_reg.mcr & UDR_MCR_ENH_MASK));
                    UDR_A_SPR: begin
                        // Level-counter view drops the write; spr keeps its value
                        if (!state_reg.feature_control[UDR_FEATURE_CONTROL_SWAP_BIT]) begin
                            state_next.spr = i_wdata;
                        end
                    end
                    default: state_next.spr = state_reg.spr;
                endcase
            end
        end
        // FIFO pointers; a full FIFO drops the push
        if (push) begin
            state_next.wptr = state_reg.wptr + 1'b1;
        end
        if (pop) begin
            state_next.rptr = state_reg.rptr + 1'b1;
        end
        state_next.cnt = state_reg.cnt + CW'(push) - CW'(pop);
        // Receive FIFO reset bit is self clearing
        if (i_wr && !enh_bank && !div_sel && i_addr == UDR_A_ISR &&
            i_wdata[UDR_FCR_RXRST_BIT]) begin
            state_next.wptr = '0;
            state_next.rptr = '0;
            state_next.cnt = '0;
            state_next.fifo_control[UDR_FCR_RXRST_BIT] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_reg <= '0;
            state_reg.line_control <= UDR_REG_RST;
            state_reg.thr_empty_d <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Character store, no reset needed
    always_ff @(posedge i_clk) begin
        if (push) begin
            fifo_mem[state_reg.wptr] <= i_rx_char;
        end
    end

    assign o_rdata = state_reg.rdata;
    assign o_tx_write = state_reg.tx_wr;
    assign o_tx_data = state_reg.tx_data;
    assign o_irq = irq_pend;
endmodule
`default_nettype wire

// ==== test/udr_regs_checker.sv ====
// Concurrent checks on the channel register bank ports
`timescale 1ns/1ps
`default_nettype none
module udr_regs_checker
    import udr_pkg::*;
#(
    parameter int FIFO_DEPTH = UDR_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Host bus
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Channel side
    input wire logic i_rx_push,
    input wire logic [7:0] i_rx_char,
    input wire logic [3:0] i_line_err,
    input wire logic i_rx_timeout,
    input wire logic i_thr_empty,
    input wire logic i_tsr_empty,
    input wire logic o_tx_write,
    input wire logic [7:0] o_tx_data,
    input wire logic [7:0] i_modem_status,
    input wire logic o_irq
);
    // Shadow of the registers that steer decode and the receive interrupt
    typedef struct packed {
        logic [7:0] line_control;
        logic efr4;
        logic fcr0;
        logic [3:0] interrupt_enable;
        logic [7:0] fifo_trigger_level;
        logic [7:0] cnt;
    } udr_chk_t;
    udr_chk_t cur_reg;
    udr_chk_t cur_next;
    logic bank; // Enhanced bank selected
    logic rx_src; // Receive source as the host should see it
    logic quiet; // Only the receive source can be pending
    assign bank = cur_reg.line_control == UDR_ENH_KEY;
    assign rx_src = cur_reg.interrupt_enable[0] && cur_reg.cnt != 8'h00
        && (!cur_reg.fcr0 || cur_reg.cnt >= cur_reg.fifo_trigger_level);
    assign quiet = cur_reg.interrupt_enable[3:1] == 3'h0 && !i_rx_timeout;

    ////////////////////////////////////////////////////////////////////
    // Shadow update; FIFO reset is applied last so that it wins
    always_comb begin
        cur_next = cur_reg;
        if (i_wr && i_addr == UDR_A_LCR) cur_next.line_control = i_wdata;
        if (i_wr && bank && i_addr == 3'h2) cur_next.efr4 = i_wdata[4];
        if (i_wr && bank && i_addr == 3'h0) cur_next.fifo_trigger_level = i_wdata;
        if (i_wr && !cur_reg.line_control[7] && i_addr == UDR_A_IER) cur_next.interrupt_enable = i_wdata[3:0];
        if (i_rx_push && cur_reg.cnt < FIFO_DEPTH) cur_next.cnt = cur_next.cnt + 8'h01;
        if (i_rd && !cur_reg.line_control[7] && i_addr == UDR_A_DATA && cur_reg.cnt != 8'h00) begin
            cur_next.cnt = cur_next.cnt - 8'h01;
        end
        if (i_wr && !cur_reg.line_control[7] && i_addr == UDR_A_ISR) begin
            cur_next.fcr0 = i_wdata[0];
            if (i_wdata[1]) cur_next.cnt = 8'h00;
        end
    end

    // Shadow register, cleared with the design
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    tx_pulse_a: assert property (i_wr && i_addr == UDR_A_DATA && !cur_reg.line_control[7]
        |=> o_tx_write && o_tx_data == $past(i_wdata)) else $error("transmit write missing");
    div_no_tx_a: assert property (i_wr && i_addr == UDR_A_DATA && cur_reg.line_control[7]
        |=> !o_tx_write) else $error("divisor write reached transmitter");
    tx_cause_a: assert property (o_tx_write
        |-> $past(i_wr) && $past(i_addr) == UDR_A_DATA) else $error("stray transmit write");
    ready_bit_a: assert property (i_rd && i_addr == UDR_A_LSR && !bank
        |=> o_rdata[0] == $past(cur_reg.cnt != 8'h00)) else $error("data ready bit wrong");
    enh_zero_a: assert property (i_rd && i_addr == UDR_A_IER && !cur_reg.line_control[7]
        && !cur_reg.efr4 |=> o_rdata[7:4] == 4'h0) else $error("enhanced bits not zero");
    irq_follow_a: assert property (quiet |-> o_irq == rx_src)
        else $error("receive interrupt output wrong");
    isr_code_a: assert property (i_rd && i_addr == UDR_A_ISR && !cur_reg.line_control[7]
        && quiet |=> o_rdata == {$past(cur_reg.fcr0), $past(cur_reg.fcr0),
        ($past(rx_src) ? UDR_ISR_RECEIVE_READY_EVENT : UDR_ISR_NONE)}) else $error("status code wrong");
    tmo_first_a: assert property (i_rd && i_addr == UDR_A_ISR && !cur_reg.line_control[7]
        && i_rx_timeout && (!cur_reg.interrupt_enable[2] || i_line_err == 4'h0)
        |=> o_rdata[5:0] == UDR_ISR_TMO) else $error("timeout not above receive ready");
    rdata_hold_a: assert property (!$past(i_rd) |-> $stable(o_rdata))
        else $error("read data changed without a read");

    // Main scenarios reached
    cover property (rx_src && cur_reg.fcr0);
    cover property (o_tx_write);
    cover property (i_rd && i_addr == UDR_A_ISR && i_rx_timeout);
endmodule
`default_nettype wire

// ==== test/udr_host_model.sv ====
// Host processor model driving the channel bus
`timescale 1ns/1ps
`default_nettype none
module udr_host_model
    import udr_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Bus toward the channel
    output logic [2:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd,
    input wire logic [7:0] i_rdata
);
    // Idle bus at time zero
    initial begin
        o_addr = 3'h0;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    // One-cycle write strobe; data then flips so nothing relies on a stale bus
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(posedge i_clk);
        #1;
        o_wr = 1'b0;
        o_wdata = ~d;
    endtask

    // One-cycle read strobe; answer is registered at the taking edge
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_rd = 1'b1;
        @(posedge i_clk);
        #1;
        o_rd = 1'b0;
        d = i_rdata;
    endtask

    // Key write that opens the enhanced bank
    task automatic open_bank();
        wr(UDR_A_LCR, UDR_ENH_KEY);
    endtask
endmodule
`default_nettype wire

// ==== test/uart_divisor_enhanced_regs_rx_irq_tb_top.sv ====
// Self-checking bench for the channel register bank
`timescale 1ns/1ps
`default_nettype none
module uart_divisor_enhanced_regs_rx_irq_tb_top;
    import udr_pkg::*;
    localparam int DEPTH = 8; // Small FIFO so that it fills quickly
    localparam logic [7:0] REV = 8'h3A; // Arbitrary value
    localparam logic [7:0] PID = 8'h6B; // Arbitrary value
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, rx_char, tx_data;
    logic wr, rd, tx_write, irq;
    logic push = 1'b0;
    logic [3:0] line_err = 4'h0;
    logic tmo = 1'b0;
    logic thr_e = 1'b1;
    logic tsr_e = 1'b1;
    logic [7:0] modem = 8'h30;
    int n_mismatch = 0;
    int compares = 0;

    always #2 i_clk = ~i_clk;

    udr_host_model u_host (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
        .o_rd(rd), .i_rdata(rdata));
    udr_regs #(.FIFO_DEPTH(DEPTH), .REV_CODE(REV), .PART_ID(PID)) u_dut (.i_clk(i_clk),
        .i_reset(i_reset), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_rx_push(push), .i_rx_char(rx_char), .i_line_err(line_err),
        .i_rx_timeout(tmo), .i_thr_empty(thr_e), .i_tsr_empty(tsr_e), .o_tx_write(tx_write),
        .o_tx_data(tx_data), .i_modem_status(modem), .o_irq(irq));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic w(input logic [2:0] a, input logic [7:0] d);
        u_host.wr(a, d);
    endtask
    task automatic r(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host.rd(a, d);
        chk(d, e);
    endtask
    // Receiver hands one character to the FIFO
    task automatic put(input logic [7:0] c);
        @(posedge i_clk);
        #1;
        push = 1'b1;
        rx_char = c;
        @(posedge i_clk);
        #1;
        push = 1'b0;
        rx_char = ~c;
    endtask
    task automatic end_of_test();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Values straight after reset
    task automatic t_reset();
        r(UDR_A_IER, 8'h00);
        r(UDR_A_ISR, 8'h01);
        r(UDR_A_LSR, 8'h60);
        r(UDR_A_MSR, 8'h30);
    endtask
    // Divisor view, identity while divisor is zero, fraction locked
    task automatic t_div();
        w(UDR_A_LCR, 8'h80);
        r(3'h0, REV);
        r(3'h1, PID);
        w(3'h0, 8'h12);
        w(3'h1, 8'h34);
        w(3'h2, 8'hFF);
        r(3'h0, 8'h12);
        r(3'h1, 8'h34);
        r(3'h2, 8'h00);
        w(UDR_A_LCR, 8'h03);
        r(UDR_A_LCR, 8'h03);
    endtask
    // Enhanced bank, then enhanced bits with the enable on and off
    task automatic t_enh();
        int i;
        u_host.open_bank();
        w(3'h2, 8'h10);
        for (i = 4; i < 8; i++) w(3'(i), 8'(i * 17));
        for (i = 4; i < 8; i++) r(3'(i), 8'(i * 17));
        r(3'h2, 8'h10);
        w(UDR_A_LCR, 8'h80);
        w(3'h2, 8'hFF);
        r(3'h2, 8'h0F);
        w(UDR_A_LCR, 8'h00);
        w(UDR_A_IER, 8'hF0);
        r(UDR_A_IER, 8'hF0);
        w(UDR_A_IER, 8'h00);
        u_host.open_bank();
        w(3'h2, 8'h00);
        w(UDR_A_LCR, 8'h00);
        w(UDR_A_IER, 8'hF0);
        r(UDR_A_IER, 8'h00);
    endtask
    // Trigger level 4: rise, status code, withdrawal, fill to full, flush
    task automatic t_rx();
        int i;
        u_host.open_bank();
        w(3'h0, 8'h04);
        w(UDR_A_LCR, 8'h00);
        w(UDR_A_ISR, 8'h01);
        w(UDR_A_IER, 8'h01);
        for (i = 0; i < 3; i++) put(8'(8'hC0 + i));
        chk({7'h00, irq}, 8'h00);
        r(UDR_A_LSR, 8'h61);
        put(8'hC3);
        chk({7'h00, irq}, 8'h01);
        r(UDR_A_ISR, 8'hC4);
        r(UDR_A_DATA, 8'hC0);
        chk({7'h00, irq}, 8'h00);
        r(UDR_A_ISR, 8'hC1);
        for (i = 1; i < 4; i++) r(UDR_A_DATA, 8'(8'hC0 + i));
        r(UDR_A_LSR, 8'h60);
        for (i = 0; i <= DEPTH; i++) put(8'(i));
        u_host.open_bank();
        r(3'h0, 8'(DEPTH));
        w(3'h1, 8'h40);
        w(UDR_A_LCR, 8'h00);
        r(UDR_A_SPR, 8'(DEPTH));
        w(UDR_A_ISR, 8'h03);
        r(UDR_A_SPR, 8'h00);
        r(UDR_A_LSR, 8'h60);
    endtask
    // Transmit write, then the transmit, line status, timeout and modem sources one at a time
    task automatic t_src();
        w(UDR_A_IER, 8'h00);
        w(UDR_A_DATA, 8'hA5);
        chk({7'h00, tx_write}, 8'h01);
        chk(tx_data, 8'hA5);
        w(UDR_A_IER, 8'h02);
        chk({7'h00, irq}, 8'h01);
        r(UDR_A_ISR, 8'hC2);
        r(UDR_A_ISR, 8'hC1);
        w(UDR_A_IER, 8'h04);
        line_err = 4'h2;
        r(UDR_A_ISR, 8'hC6);
        w(UDR_A_IER, 8'h00);
        line_err = 4'h0;
        tmo = 1'b1;
        r(UDR_A_ISR, 8'hCC);
        tmo = 1'b0;
        w(UDR_A_IER, 8'h08);
        modem = 8'h31;
        r(UDR_A_ISR, 8'hC0);
        modem = 8'h30;
        w(UDR_A_IER, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        rx_char = 8'h00;
        repeat (16) @(posedge i_clk);
        #1;
        i_reset = 1'b0;
        t_reset();
        t_div();
        t_enh();
        t_rx();
        t_src();
        end_of_test();
    end
    // Bounded run: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge i_clk);
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire

bind udr_regs udr_regs_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.i_clk(i_clk),
    .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_rx_push(i_rx_push), .i_rx_char(i_rx_char), .i_line_err(i_line_err),
    .i_rx_timeout(i_rx_timeout), .i_thr_empty(i_thr_empty), .i_tsr_empty(i_tsr_empty),
    .o_tx_write(o_tx_write), .o_tx_data(o_tx_data), .i_modem_status(i_modem_status),
    .o_irq(o_irq));
